/* src/dmarc_regs.svh */
`ifndef DMARC_REGS_SVH
`define DMARC_REGS_SVH

// Register byte offsets within one channel.
`define DMARC_OFF_MEM_PTR      8'h00
`define DMARC_OFF_PERIPH       8'h04
`define DMARC_OFF_REMAIN       8'h08
`define DMARC_OFF_PTR_RELOAD   8'h0C
`define DMARC_OFF_CNT_RELOAD   8'h10
`define DMARC_OFF_COMMAND      8'h14
`define DMARC_OFF_MODE         8'h18
`define DMARC_OFF_STATE        8'h1C
`define DMARC_OFF_IRQ_UNMASK   8'h20
`define DMARC_OFF_IRQ_MASK_OFF 8'h24
`define DMARC_OFF_IRQ_EN_STATE 8'h28
`define DMARC_OFF_IRQ_FLAG     8'h2C

// Command bit positions.
`define DMARC_CMD_ENABLE_BIT   0
`define DMARC_CMD_DISABLE_BIT  1
`define DMARC_CMD_ERRCLR_BIT   8

// Mode field positions.
`define DMARC_MODE_SIZE_LSB    0
`define DMARC_MODE_EVENT_BIT   2
`define DMARC_MODE_RING_BIT    3

// Flag positions in the flag, mask, unmask and mask-off registers.
`define DMARC_FLAG_RELOAD_EMPTY 0
`define DMARC_FLAG_ALL_DONE     1
`define DMARC_FLAG_ERROR        2

// Transfer size codes.
`define DMARC_SIZE_BYTE  2'h0
`define DMARC_SIZE_HALF  2'h1
`define DMARC_SIZE_WORD  2'h2

// Reset values.
`define DMARC_RST_WORD   32'h00000000
`define DMARC_RST_COUNT  16'h0000
`define DMARC_RST_PID    6'h00

`endif

/* src/dmarc_pkg.sv */
`default_nettype none

package dmarc_pkg;

  // Channel sequencing states.
  typedef enum logic [1:0] {
    DMARC_IDLE = 2'b00,
    DMARC_WAIT = 2'b01,
    DMARC_XFER = 2'b10
  } dmarc_state_e;

  // Item request to the bus master datapath.
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [5:0]  pid;
  } dmarc_xfer_s;

  // Software register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dmarc_bus_s;

endpackage

`default_nettype wire

/* src/dmarc_channel.sv */
// Contract
// - At counter zero with nonzero count reload, copy pointer reload into pointer.
// - At counter zero, reload counter from count reload value when above zero.
// - Zero count reload at counter expiry stops further transfers.
// - Each counter reload clears the count reload register unless ring mode.
// - Ring mode keeps both reload registers after reload so buffer repeats.
// - Command bit 8 clears error flag, allowing transfers; zero bits do nothing.
// - Command bit 1 disables channel transfers.
// - Command bit 0 enables channel transfers.
// - State bit 0 shows enabled; cleared by disable, set by enable.
// - Mode bit 2 picks peripheral request or event-started transfer.
// - Size field: 0 byte, 1 halfword, 2 word; 3 reserved.
// - Unmask register ones set mask bits: 2 error, 1 done, 0 empty.
// - Mask-off register ones clear matching mask bits.
// - Readable mask bit one means that interrupt is enabled.
// - Error flag set after any error since reset or last clear.
// - All-done flag set while counter and count reload are both zero.
// - Reload-empty flag set while count reload register is zero.
// - Memory pointer holds the next location to access during transfer.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dmarc_regs.svh"

module dmarc_channel
  import dmarc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PID_W = 6
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Software register port.
  input  wire dmarc_bus_s  bus_req,
  output logic [31:0]      bus_rdata,
  // Peripheral handshake and event, from other clock-free sources.
  input  wire logic        periph_req,
  input  wire logic        periph_event,
  // Bus master datapath.
  output dmarc_xfer_s      xfer_req,
  input  wire logic        item_done,
  input  wire logic        item_error,
  // Channel interrupt.
  output logic             chan_irq
);

  logic [31:0]      mem_ptr_r;
  logic [31:0]      ptr_reload_r;
  logic [CNT_W-1:0] remain_r;
  logic [CNT_W-1:0] cnt_reload_r;
  logic [PID_W-1:0] pid_r;
  logic [1:0]       size_r;
  logic             event_sel_r;
  logic             ring_r;
  logic             enabled_r;
  logic             err_flag_r;
  logic [2:0]       irq_mask_r;
  logic [2:0]       flags;
  logic             event_seen_r;
  logic [1:0]       req_sync_r;
  logic [1:0]       evt_sync_r;
  logic             wr_cmd;
  logic             expire;
  logic             can_start;
  logic [31:0]      step;
  dmarc_state_e     state_r;
  dmarc_state_e     state_nxt;

  // All checks below share this one clock domain and its reset.
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Pins from peripherals may be asynchronous, so each passes two flops.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      req_sync_r <= 2'h0;
      evt_sync_r <= 2'h0;
    end else begin
      req_sync_r <= {req_sync_r[0], periph_req};
      evt_sync_r <= {evt_sync_r[0], periph_event};
    end
  end

  assign wr_cmd = bus_req.wr && (bus_req.addr == `DMARC_OFF_COMMAND);

  // Counter reaching zero on the last item triggers the reload step.
  assign expire = item_done && (remain_r == CNT_W'(1));

  // Status flags are live views of counters plus the sticky error.
  always_comb begin
    flags = 3'h0;
    flags[`DMARC_FLAG_ERROR]        = err_flag_r;
    flags[`DMARC_FLAG_ALL_DONE]     = (remain_r == '0) &&
                                      (cnt_reload_r == '0);
    flags[`DMARC_FLAG_RELOAD_EMPTY] = (cnt_reload_r == '0);
  end

  // Item width in bytes; the reserved code falls back to a byte step.
  always_comb begin
    case (size_r)
      `DMARC_SIZE_HALF: step = 32'h00000002;
      `DMARC_SIZE_WORD: step = 32'h00000004;
      default:          step = 32'h00000001;
    endcase
  end

  // Start condition: direct request, or a remembered event plus request.
  assign can_start = enabled_r && !err_flag_r && (remain_r != '0) &&
                     req_sync_r[1] &&
                     (!event_sel_r || event_seen_r);

  // Event latch: an event counts if it came before or at the request.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      event_seen_r <= 1'b0;
    end else if (state_r == DMARC_XFER && item_done) begin
      event_seen_r <= evt_sync_r[1];
    end else if (evt_sync_r[1]) begin
      event_seen_r <= 1'b1;
    end
  end

  // Sequencer: one item outstanding at a time so the pointer stays exact.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DMARC_IDLE: begin
        if (can_start) begin
          state_nxt = DMARC_XFER;
        end
      end
      DMARC_XFER: begin
        if (item_done || item_error) begin
          state_nxt = DMARC_WAIT;
        end
      end
      DMARC_WAIT: state_nxt = DMARC_IDLE;
      default:    state_nxt = DMARC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r <= DMARC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Item request to the datapath straight from flops.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      xfer_req <= '0;
    end else begin
      xfer_req.valid <= (state_nxt == DMARC_XFER);
      xfer_req.addr  <= mem_ptr_r;
      xfer_req.size  <= size_r;
      xfer_req.pid   <= pid_r;
    end
  end

  // An empty counter must never launch an item.
  stop_zero_a: assert property (
    (remain_r == '0) |=> !xfer_req.valid)
    else $error("transfer with zero count");

  // Pointer: software write, advance per item, or reload at expiry.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_ptr_r <= `DMARC_RST_WORD;
    end else if (state_r == DMARC_XFER && item_done) begin
      if (expire && cnt_reload_r != '0) begin
        mem_ptr_r <= ptr_reload_r;
      end else begin
        mem_ptr_r <= mem_ptr_r + step;
      end
    end else if (bus_req.wr && bus_req.addr == `DMARC_OFF_MEM_PTR) begin
      mem_ptr_r <= bus_req.wdata;
    end
  end

  // Reload step: the last item ends while a nonzero count reload waits.
  sequence reload_step_s;
    state_r == DMARC_XFER && expire && cnt_reload_r != '0;
  endsequence

  // Pointer either jumps to the reload value or advances by one item.
  reload_ptr_a: assert property (
    reload_step_s |=> mem_ptr_r == $past(ptr_reload_r))
    else $error("pointer not reloaded");
  ptr_step_a: assert property (
    state_r == DMARC_XFER && item_done && !expire && !bus_req.wr
    |=> mem_ptr_r == $past(mem_ptr_r) + $past(step))
    else $error("pointer step wrong");

  // Remaining count: decrement per item, reload from nonzero reload value.
  // A zero reload leaves it at zero, so the channel simply stops.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      remain_r <= `DMARC_RST_COUNT;
    end else if (state_r == DMARC_XFER && item_done) begin
      if (expire && cnt_reload_r != '0) begin
        remain_r <= cnt_reload_r;
      end else begin
        remain_r <= remain_r - CNT_W'(1);
      end
    end else if (bus_req.wr && bus_req.addr == `DMARC_OFF_REMAIN) begin
      remain_r <= bus_req.wdata[CNT_W-1:0];
    end
  end

  // Counter takes the reload value on the reload step.
  reload_cnt_a: assert property (
    reload_step_s |=> remain_r == $past(cnt_reload_r))
    else $error("counter not reloaded");

  // Reload registers; hardware clear wins over a same-cycle software write.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_reload_r <= `DMARC_RST_COUNT;
      ptr_reload_r <= `DMARC_RST_WORD;
    end else begin
      if (state_r == DMARC_XFER && expire && cnt_reload_r != '0 && !ring_r) begin
        cnt_reload_r <= '0;
      end else if (bus_req.wr && bus_req.addr == `DMARC_OFF_CNT_RELOAD) begin
        cnt_reload_r <= bus_req.wdata[CNT_W-1:0];
      end
      if (bus_req.wr && bus_req.addr == `DMARC_OFF_PTR_RELOAD) begin
        ptr_reload_r <= bus_req.wdata;
      end
    end
  end

  // Count reload is cleared after use, except in ring mode.
  reload_clear_a: assert property (
    reload_step_s ##0 !ring_r |=> cnt_reload_r == '0)
    else $error("reload not cleared");
  ring_keep_a: assert property (
    state_r == DMARC_XFER && expire && ring_r && !bus_req.wr
    |=> $stable(cnt_reload_r))
    else $error("ring reload changed");

  // Mode and peripheral select registers.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      size_r      <= `DMARC_SIZE_BYTE;
      event_sel_r <= 1'b0;
      ring_r      <= 1'b0;
      pid_r       <= `DMARC_RST_PID;
    end else begin
      if (bus_req.wr && bus_req.addr == `DMARC_OFF_MODE) begin
        size_r      <= bus_req.wdata[`DMARC_MODE_SIZE_LSB +: 2];
        event_sel_r <= bus_req.wdata[`DMARC_MODE_EVENT_BIT];
        ring_r      <= bus_req.wdata[`DMARC_MODE_RING_BIT];
      end
      if (bus_req.wr && bus_req.addr == `DMARC_OFF_PERIPH) begin
        pid_r <= bus_req.wdata[PID_W-1:0];
      end
    end
  end

  // Enable state; disable has priority if both bits are written together.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      enabled_r <= 1'b0;
    end else if (wr_cmd && bus_req.wdata[`DMARC_CMD_DISABLE_BIT]) begin
      enabled_r <= 1'b0;
    end else if (wr_cmd && bus_req.wdata[`DMARC_CMD_ENABLE_BIT]) begin
      enabled_r <= 1'b1;
    end
  end

  // Enable and disable commands reach the state bit one cycle later.
  enable_cmd_a: assert property (
    (wr_cmd && bus_req.wdata[`DMARC_CMD_ENABLE_BIT] &&
     !bus_req.wdata[`DMARC_CMD_DISABLE_BIT]) |=> enabled_r)
    else $error("enable missed");
  disable_cmd_a: assert property (
    (wr_cmd && bus_req.wdata[`DMARC_CMD_DISABLE_BIT]) |=> !enabled_r)
    else $error("disable missed");

  // Sticky error; a new error in the clear cycle is kept, never lost.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      err_flag_r <= 1'b0;
    end else if (state_r == DMARC_XFER && item_error) begin
      err_flag_r <= 1'b1;
    end else if (wr_cmd && bus_req.wdata[`DMARC_CMD_ERRCLR_BIT]) begin
      err_flag_r <= 1'b0;
    end
  end

  // A clear with no competing error empties the flag.
  err_clear_a: assert property (
    (wr_cmd && bus_req.wdata[`DMARC_CMD_ERRCLR_BIT] && !item_error)
    |=> !err_flag_r)
    else $error("error not cleared");

  // Mask set by unmask writes, cleared by mask-off writes, per bit.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_mask
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          irq_mask_r[gi] <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == `DMARC_OFF_IRQ_MASK_OFF &&
                     bus_req.wdata[gi]) begin
          irq_mask_r[gi] <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == `DMARC_OFF_IRQ_UNMASK &&
                     bus_req.wdata[gi]) begin
          irq_mask_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Interrupt registered so the output comes from a flop.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      chan_irq <= 1'b0;
    end else begin
      chan_irq <= |(flags & irq_mask_r);
    end
  end

  // An unmasked flag raises the interrupt on the next edge.
  irq_out_a: assert property (
    |(flags & irq_mask_r) |=> chan_irq)
    else $error("interrupt missing");

  // Read data in the cycle after the strobe; write-only reads as zero.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bus_rdata <= `DMARC_RST_WORD;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `DMARC_OFF_MEM_PTR:      bus_rdata <= mem_ptr_r;
        `DMARC_OFF_PERIPH:       bus_rdata <= 32'(pid_r);
        `DMARC_OFF_REMAIN:       bus_rdata <= 32'(remain_r);
        `DMARC_OFF_PTR_RELOAD:   bus_rdata <= ptr_reload_r;
        `DMARC_OFF_CNT_RELOAD:   bus_rdata <= 32'(cnt_reload_r);
        `DMARC_OFF_MODE:         bus_rdata <= {28'h0000000, ring_r,
                                               event_sel_r, size_r};
        `DMARC_OFF_STATE:        bus_rdata <= {31'h00000000, enabled_r};
        `DMARC_OFF_IRQ_EN_STATE: bus_rdata <= {29'h00000000,
                                               irq_mask_r};
        `DMARC_OFF_IRQ_FLAG:     bus_rdata <= {29'h00000000, flags};
        default:                 bus_rdata <= 32'h00000000;
      endcase
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

/* sim/dmarc_xfer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dmarc_xfer_model
  import dmarc_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Item link from the channel.
  input  wire dmarc_xfer_s xfer_req,
  // Behaviour controls from the bench.
  input  wire logic [3:0]  lat,
  input  wire logic        fail,
  // Completion back to the channel.
  output logic             item_done,
  output logic             item_error
);
  logic [3:0] wait_r;
  logic       busy_r;

  // One answer per item after lat cycles; busy_r holds until valid drops,
  // because valid stands one cycle past the answer and must not be paid twice.
  always_ff @(posedge core_clk) begin
    item_done  <= 1'b0;
    item_error <= 1'b0;
    if (!rst_b || !xfer_req.valid) begin
      wait_r <= 4'h0;
      busy_r <= 1'b0;
    end else if (!busy_r) begin
      if (wait_r >= lat) begin
        busy_r     <= 1'b1;
        item_done  <= !fail;
        item_error <= fail;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

/* sim/tb_dmarc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmarc_regs.svh"

module tb_dmarc_channel
  import dmarc_pkg::*;
;
  logic        core_clk;
  logic        rst_b;
  dmarc_bus_s  bus_req;
  logic [31:0] bus_rdata;
  logic        periph_req;
  logic        periph_event;
  dmarc_xfer_s xfer_req;
  logic        item_done;
  logic        item_error;
  logic        chan_irq;
  logic [3:0]  lat;
  logic        fail;
  logic [31:0] seen[$];
  int          fails;
  int          n_tests;

  dmarc_channel dmarc_channel_inst (.core_clk(core_clk), .rst_b(rst_b),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .periph_req(periph_req),
    .periph_event(periph_event), .xfer_req(xfer_req),
    .item_done(item_done), .item_error(item_error), .chan_irq(chan_irq));

  dmarc_xfer_model dmarc_xfer_model_inst (.core_clk(core_clk),
    .rst_b(rst_b), .xfer_req(xfer_req), .lat(lat), .fail(fail),
    .item_done(item_done), .item_error(item_error));

  // Free-running 40 MHz clock.
  always #12.5 core_clk = ~core_clk;

  // Record the pointer of every item that completed cleanly.
  always @(posedge core_clk) begin
    if (rst_b && xfer_req.valid === 1'b1 && item_done === 1'b1) begin
      seen.push_back(xfer_req.addr);
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus tasks start just after an edge and leave one idle cycle behind.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFFFFFF);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 check(bus_rdata & m, exp);
    @(posedge core_clk);
  endtask

  // Bounded wait for n clean items; running out is a mismatch.
  task automatic wait_items(input int n);
    int i;
    for (i = 0; i < 500 && seen.size() < n; i++) @(posedge core_clk);
    if (seen.size() < n) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, seen.size(), n);
      end_sim();
    end
  endtask

  task automatic setup(input logic [31:0] p, c, pr, cr, md);
    wr(`DMARC_OFF_COMMAND, 32'h00000002);
    seen.delete();
    wr(`DMARC_OFF_MEM_PTR, p);
    wr(`DMARC_OFF_REMAIN, c);
    wr(`DMARC_OFF_PTR_RELOAD, pr);
    wr(`DMARC_OFF_CNT_RELOAD, cr);
    wr(`DMARC_OFF_MODE, md);
  endtask

  task automatic t_reset();
    rd(`DMARC_OFF_STATE, 32'h00000000);
    rd(`DMARC_OFF_IRQ_EN_STATE, 32'h00000000);
    rd(`DMARC_OFF_IRQ_FLAG, 32'h00000003);
    rd(`DMARC_OFF_CNT_RELOAD, 32'h00000000);
    rd(`DMARC_OFF_COMMAND, 32'h00000000);
  endtask

  task automatic t_enable();
    wr(`DMARC_OFF_COMMAND, 32'h00000001);
    rd(`DMARC_OFF_STATE, 32'h00000001);
    wr(`DMARC_OFF_COMMAND, 32'h00000000);
    rd(`DMARC_OFF_STATE, 32'h00000001);
    wr(`DMARC_OFF_COMMAND, 32'h00000002);
    rd(`DMARC_OFF_STATE, 32'h00000000);
    wr(`DMARC_OFF_COMMAND, 32'h00000003);
    rd(`DMARC_OFF_STATE, 32'h00000000);
  endtask

  // Ends one edge after the last check so the next task starts on an edge.
  task automatic t_irq();
    wr(`DMARC_OFF_IRQ_UNMASK, 32'h00000007);
    rd(`DMARC_OFF_IRQ_EN_STATE, 32'h00000007);
    wr(`DMARC_OFF_IRQ_UNMASK, 32'h00000000);
    wr(`DMARC_OFF_IRQ_MASK_OFF, 32'h00000002);
    rd(`DMARC_OFF_IRQ_EN_STATE, 32'h00000005);
    check(chan_irq, 1'b1);
    wr(`DMARC_OFF_IRQ_MASK_OFF, 32'h00000001);
    @(posedge core_clk);
    #1 check(chan_irq, 1'b0);
    @(posedge core_clk);
  endtask

  // Word items, one reload, then a stop once both counts are spent.
  task automatic t_reload();
    setup(32'h100, 32'h2, 32'h400, 32'h3, 32'h2);
    rd(`DMARC_OFF_IRQ_FLAG, 32'h00000000);
    lat        <= 4'h2;
    periph_req <= 1'b1;
    wr(`DMARC_OFF_COMMAND, 32'h00000001);
    wait_items(5);
    repeat (30) @(posedge core_clk);
    check(seen.size(), 5);
    check(seen[0], 32'h00000100);
    check(seen[1], 32'h00000104);
    check(seen[2], 32'h00000400);
    check(seen[3], 32'h00000404);
    check(seen[4], 32'h00000408);
    rd(`DMARC_OFF_CNT_RELOAD, 32'h00000000);
    rd(`DMARC_OFF_MEM_PTR, 32'h0000040C);
    rd(`DMARC_OFF_REMAIN, 32'h00000000);
    rd(`DMARC_OFF_IRQ_FLAG, 32'h00000003);
  endtask

  // Byte items in ring mode repeat the reload buffer.
  task automatic t_ring();
    setup(32'h10, 32'h1, 32'h20, 32'h2, 32'h8);
    lat <= 4'h0;
    wr(`DMARC_OFF_COMMAND, 32'h00000001);
    wait_items(5);
    wr(`DMARC_OFF_COMMAND, 32'h00000002);
    check(seen[0], 32'h10);
    for (int i = 1; i < 5; i++) check(seen[i], 32'h20 + (i + 1) % 2);
    rd(`DMARC_OFF_CNT_RELOAD, 32'h00000002);
    rd(`DMARC_OFF_PTR_RELOAD, 32'h00000020);
  endtask

  // A failed item stops the channel until the error is cleared.
  task automatic t_error();
    setup(32'h200, 32'h2, 32'h0, 32'h0, 32'h1);
    wr(`DMARC_OFF_IRQ_UNMASK, 32'h00000004);
    fail <= 1'b1;
    wr(`DMARC_OFF_COMMAND, 32'h00000001);
    repeat (30) @(posedge core_clk);
    rd(`DMARC_OFF_IRQ_FLAG, 32'h00000004, 32'h00000004);
    check(chan_irq, 1'b1);
    check(xfer_req.valid, 1'b0);
    fail <= 1'b0;
    wr(`DMARC_OFF_MEM_PTR, 32'h300);
    wr(`DMARC_OFF_REMAIN, 32'h2);
    wr(`DMARC_OFF_COMMAND, 32'h00000100);
    rd(`DMARC_OFF_IRQ_FLAG, 32'h00000000, 32'h00000004);
    wait_items(2);
    check(seen[0], 32'h300);
    check(seen[1], 32'h302);
    check(chan_irq, 1'b0);
    wr(`DMARC_OFF_IRQ_MASK_OFF, 32'h00000007);
  endtask

  // Event start: a level request alone must not launch an item.
  task automatic t_event();
    setup(32'h500, 32'h1, 32'h0, 32'h0, 32'h6);
    wr(`DMARC_OFF_PERIPH, 32'h00000025);
    rd(`DMARC_OFF_PERIPH, 32'h00000025);
    wr(`DMARC_OFF_COMMAND, 32'h00000001);
    repeat (20) @(posedge core_clk);
    check(seen.size(), 0);
    periph_event <= 1'b1;
    @(posedge core_clk);
    periph_event <= 1'b0;
    wait_items(1);
    check(seen[0], 32'h500);
    check(xfer_req.size, `DMARC_SIZE_WORD);
    check(xfer_req.pid, 6'h25);
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    core_clk     = 1'b0;
    rst_b        = 1'b0;
    bus_req      = '0;
    periph_req   = 1'b0;
    periph_event = 1'b0;
    lat          = 4'h1;
    fail         = 1'b0;
    fails        = 0;
    n_tests      = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1 check(chan_irq, 1'b0);
    @(posedge core_clk);
    t_reset();
    t_enable();
    t_irq();
    t_reload();
    t_ring();
    t_error();
    t_event();
    end_sim();
  end
endmodule

`default_nettype wire
